// *** hdl/mcc_pkg.sv ***
// shared constants of the 8-bit core: opcode fields, lengths, data space addresses
// assumes nothing; every core file refers to it as mcc_pkg::name
`default_nettype none

package mcc_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int PC_W = 12;
    localparam int DW = 8;
    localparam int STACK_DEPTH = 6;
    localparam int SP_W = 3;
    localparam int CNT_W = 3;

    // ------------------------------------------------------------
    // opcode fields
    // ------------------------------------------------------------
    localparam int KIND_HI = 7;
    localparam int KIND_LO = 5;
    localparam int DIR_BIT = 4;      // relative branch: 1 = backward
    localparam int SPAN_HI = 3;      // relative branch span 0..15
    localparam int SUB_HI = 4;       // sub-operation field of alu group
    localparam int SUB_LO = 2;
    localparam int MODE_HI = 1;      // addressing mode of alu group
    localparam int BOP_HI = 4;       // bit group operation
    localparam int BOP_LO = 3;
    localparam int BIT_HI = 2;       // 3-bit bit selector
    localparam int EXT_CALL_BIT = 4; // extended group: 1 = call
    localparam int EXT_HI = 3;       // upper nibble of 12-bit target
    localparam int CTL_HI = 4;

    // instruction groups, opcode[7:5]
    localparam logic [2:0] K_BR_NZ = 3'h0;
    localparam logic [2:0] K_BR_Z = 3'h1;
    localparam logic [2:0] K_BR_NC = 3'h2;
    localparam logic [2:0] K_BR_C = 3'h3;
    localparam logic [2:0] K_BIT = 3'h4;
    localparam logic [2:0] K_EXT = 3'h5;
    localparam logic [2:0] K_ALU = 3'h6;
    localparam logic [2:0] K_CTL = 3'h7;

    // bit group operations
    localparam logic [1:0] BOP_TEST_RESET = 2'h0;
    localparam logic [1:0] BOP_TEST_SET = 2'h1;
    localparam logic [1:0] BOP_SET = 2'h2;
    localparam logic [1:0] BOP_RESET = 2'h3;

    // alu addressing modes; mode 3 is immediate for two-operand ops, accumulator otherwise
    localparam logic [1:0] MODE_IND_X = 2'h0;
    localparam logic [1:0] MODE_IND_Y = 2'h1;
    localparam logic [1:0] MODE_DIRECT = 2'h2;
    localparam logic [1:0] MODE_IMM_ACC = 2'h3;

    // control group codes, opcode[4:0]
    localparam logic [4:0] CTL_NOP = 5'h00;
    localparam logic [4:0] CTL_RET = 5'h01;
    localparam logic [4:0] CTL_IRET = 5'h02;
    localparam logic [4:0] CTL_STOP = 5'h03;
    localparam logic [4:0] CTL_WAIT = 5'h04;
    localparam logic [4:0] CTL_COM = 5'h05;
    localparam logic [4:0] CTL_RLC = 5'h06;
    localparam logic [4:0] CTL_SLA = 5'h07;

    // alu operations
    typedef enum logic [3:0]
    {
        ALU_ADD = 4'h0,
        ALU_AND = 4'h1,
        ALU_CMP = 4'h2,
        ALU_SUB = 4'h3,
        ALU_CLR = 4'h4,
        ALU_DEC = 4'h5,
        ALU_INC = 4'h6,
        ALU_NONE = 4'h7,
        ALU_COM = 4'h8,
        ALU_RLC = 4'h9,
        ALU_SLA = 4'ha
    } mcc_alu_e;

    // core run state, gray along run -> wait -> stop
    typedef enum logic [1:0]
    {
        RUN_ST = 2'b00,
        WAIT_ST = 2'b01,
        STOP_ST = 2'b11
    } mcc_run_e;

    // ------------------------------------------------------------
    // cycle counts and step indices
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] LEN_SHORT = 3'h2;  // relative branch, control except complement/rotate/shift
    localparam logic [CNT_W-1:0] LEN_ALU = 3'h4;    // alu, set/reset, jump/call
    localparam logic [CNT_W-1:0] LEN_BTEST = 3'h5;  // bit test branch
    localparam logic [CNT_W-1:0] STEP_OPC = 3'h0;
    localparam logic [CNT_W-1:0] STEP_OPD = 3'h1;
    localparam logic [CNT_W-1:0] STEP_EXEC = 3'h2;
    localparam logic [CNT_W-1:0] STEP_WRITE = 3'h3;
    localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;

    // ------------------------------------------------------------
    // addresses and reset values
    // ------------------------------------------------------------
    localparam logic [DW-1:0] ADDR_PTR_X = 8'h80;
    localparam logic [DW-1:0] ADDR_PTR_Y = 8'h81;
    localparam logic [PC_W-1:0] PC_RESET = 12'h000;
    localparam logic [PC_W-1:0] PC_ONE = 12'h001;
    localparam logic [PC_W-1:0] PC_TWO = 12'h002;
    localparam logic [PC_W-1:0] PC_THREE = 12'h003;
    localparam logic [DW-1:0] BYTE_ZERO = 8'h00;
    localparam logic [DW-1:0] BYTE_ONE = 8'h01;

endpackage

`default_nettype wire

// *** hdl/mcc_alu.sv ***
// arithmetic and logic unit of the 8-bit core, purely combinational
// assumes the caller picks operands and decides which flags to keep
`timescale 1ns/10ps
`default_nettype none

module mcc_alu
(
    input wire mcc_pkg::mcc_alu_e op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic c_in,
    output logic [7:0] res,
    output logic z_out,
    output logic c_out
);

    logic [8:0] wide;

    // --------------------------------------------------------
    // operation select
    // --------------------------------------------------------
    // compare keeps a as result so that a stray write cannot corrupt anything
    always_comb
    begin
        wide = {1'b0, a};
        res = a;
        c_out = c_in;
        z_out = 1'b0;
        unique case (op)
            mcc_pkg::ALU_ADD:
            begin
                wide = {1'b0, a} + {1'b0, b};
                res = wide[7:0];
                c_out = wide[8];
            end
            mcc_pkg::ALU_AND:
            begin
                res = a & b;
                c_out = 1'b0;
            end
            mcc_pkg::ALU_CMP, mcc_pkg::ALU_SUB:
            begin
                wide = {1'b0, a} - {1'b0, b};
                res = (op == mcc_pkg::ALU_SUB) ? wide[7:0] : a;
                c_out = wide[8]; // borrow
            end
            mcc_pkg::ALU_CLR:
            begin
                res = mcc_pkg::BYTE_ZERO;
                c_out = 1'b0;
            end
            mcc_pkg::ALU_DEC: res = a - mcc_pkg::BYTE_ONE;
            mcc_pkg::ALU_INC: res = a + mcc_pkg::BYTE_ONE;
            mcc_pkg::ALU_COM:
            begin
                res = ~a;
                c_out = a[7];
            end
            mcc_pkg::ALU_RLC:
            begin
                res = {a[6:0], c_in};
                c_out = a[7];
            end
            mcc_pkg::ALU_SLA:
            begin
                res = {a[6:0], 1'b0};
                c_out = a[7];
            end
            default: res = a;
        endcase
        // compare reports zero on the difference, not on the kept result
        z_out = (op == mcc_pkg::ALU_CMP) ? (wide[7:0] == mcc_pkg::BYTE_ZERO)
                                         : (res == mcc_pkg::BYTE_ZERO);
    end

endmodule // mcc_alu

`default_nettype wire

// *** hdl/mcc_core.sv ***
// instruction execution of the 8-bit core: alu, branches, bit ops, control, jump/call
// assumes program and data memories answer combinationally to the registered addresses
`timescale 1ns/10ps
`default_nettype none

// Contract
// (RL1) add/and/compare/subtract use accumulator plus operand
// (RL2) clear/dec/inc reach any data space address
// (RL3) complement/rotate/shift act on accumulator only
// (RL4) flag branches taken only when condition holds
// (RL5) short branch reaches fifteen back, sixteen forward
// (RL6) bit test branch reaches -126 to +129
// (RL7) set/reset any bit via 3-bit field
// (RL8) bit test copies bit into carry only
// (RL9) bit-reset branch on zero, bit-set on one
// (RL10) halt under watchdog option acts as wait
// (RL11) jump and call use 12-bit absolute target
// (RL12) alu four cycles; inc/dec touch zero only
module mcc_core
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    output logic [11:0] pm_addr,
    input wire logic [7:0] pm_rdata,
    output logic [7:0] dm_addr,
    output logic [7:0] dm_wdata,
    output logic dm_we,
    input wire logic [7:0] dm_rdata,
    input wire logic wdog_opt_pin,
    input wire logic wake_pin,
    output logic core_waiting,
    output logic core_stopped,
    output logic [7:0] acc_out,
    output logic zero_flag,
    output logic carry_flag
);

    // --------------------------------------------------------
    // state
    // --------------------------------------------------------
    mcc_pkg::mcc_run_e run_r;
    logic [mcc_pkg::CNT_W-1:0] cnt_r;
    logic [7:0] op_r;
    logic [7:0] b1_r;
    logic [11:0] pc_r;
    logic [11:0] pm_addr_r;
    logic [11:0] stack_r [mcc_pkg::STACK_DEPTH];
    logic [mcc_pkg::SP_W-1:0] sp_r;
    logic [7:0] dm_addr_r;
    logic [7:0] dm_wdata_r;
    logic dm_we_r;
    logic [7:0] acc_r;
    logic z_r;
    logic c_r;
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [2:0] sync3_r;
    logic wdog_r;
    logic wake_r;

    // --------------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------------
    // three stages; the filtered level moves only when stages two and three agree
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
            sync3_r <= 3'h0;
        end
        else if (clk_en)
        begin
            sync1_r <= {1'b0, wake_pin, wdog_opt_pin};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // filtered option and wake levels
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wdog_r <= 1'b0;
            wake_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (sync2_r[0] == sync3_r[0])
                wdog_r <= sync3_r[0];
            if (sync2_r[1] == sync3_r[1])
                wake_r <= sync3_r[1];
        end
    end

    // --------------------------------------------------------
    // decode
    // --------------------------------------------------------
    logic [7:0] opc;
    logic [2:0] kind;
    logic [1:0] mode;
    logic [2:0] bitsel;
    logic [4:0] ctl;
    logic is_rel;
    logic is_bit;
    logic is_btest;
    logic is_ext;
    logic is_alu;
    logic is_ctl_alu;
    logic two_opnd;
    logic mem_target;
    logic [mcc_pkg::CNT_W-1:0] len;
    logic last_step;

    // at the opcode step the byte is still on the bus, later it is held in op_r
    assign opc = (cnt_r == mcc_pkg::STEP_OPC) ? pm_rdata : op_r;
    assign kind = opc[mcc_pkg::KIND_HI:mcc_pkg::KIND_LO];
    assign mode = opc[mcc_pkg::MODE_HI:0];
    assign bitsel = opc[mcc_pkg::BIT_HI:0]; // RL7
    assign ctl = opc[mcc_pkg::CTL_HI:0];
    assign is_rel = (kind <= mcc_pkg::K_BR_C);
    assign is_bit = (kind == mcc_pkg::K_BIT);
    assign is_btest = is_bit && !opc[mcc_pkg::BOP_HI];
    assign is_ext = (kind == mcc_pkg::K_EXT);
    assign is_alu = (kind == mcc_pkg::K_ALU);
    assign is_ctl_alu = (kind == mcc_pkg::K_CTL) && (ctl >= mcc_pkg::CTL_COM)
                        && (ctl <= mcc_pkg::CTL_SLA);
    assign two_opnd = (opc[mcc_pkg::SUB_HI:mcc_pkg::SUB_LO] <= 3'h3);
    // clear/dec/inc write back to memory unless the accumulator is named
    assign mem_target = is_alu && !two_opnd && (mode != mcc_pkg::MODE_IMM_ACC); // RL2

    // instruction length in cycles
    always_comb
    begin
        if (is_btest)
            len = mcc_pkg::LEN_BTEST;
        else if (is_bit || is_ext || is_alu || is_ctl_alu)
            len = mcc_pkg::LEN_ALU; // RL12
        else
            len = mcc_pkg::LEN_SHORT;
    end
    assign last_step = (cnt_r == len - mcc_pkg::CNT_ONE);

    // --------------------------------------------------------
    // alu hookup
    // --------------------------------------------------------
    mcc_pkg::mcc_alu_e alu_op;
    logic [7:0] operand;
    logic [7:0] alu_a;
    logic [7:0] alu_res;
    logic alu_z;
    logic alu_c;

    // second operand: immediate byte or data space byte per addressing mode
    assign operand = (mode == mcc_pkg::MODE_IMM_ACC) ? b1_r : dm_rdata; // RL1
    always_comb
    begin
        alu_op = mcc_pkg::ALU_NONE;
        alu_a = acc_r; // RL1 RL3
        if (is_alu)
        begin
            alu_op = mcc_pkg::mcc_alu_e'({1'b0, opc[mcc_pkg::SUB_HI:mcc_pkg::SUB_LO]});
            if (mem_target)
                alu_a = dm_rdata;
        end
        else if (is_ctl_alu)
        begin
            // accumulator-only group, no memory path exists for it
            unique case (ctl)
                mcc_pkg::CTL_COM: alu_op = mcc_pkg::ALU_COM; // RL3
                mcc_pkg::CTL_RLC: alu_op = mcc_pkg::ALU_RLC; // RL3
                default: alu_op = mcc_pkg::ALU_SLA; // RL3
            endcase
        end
    end

    mcc_alu u_alu
    (
        .op(alu_op),
        .a(alu_a),
        .b(operand),
        .c_in(c_r),
        .res(alu_res),
        .z_out(alu_z),
        .c_out(alu_c)
    );

    // --------------------------------------------------------
    // next program counter
    // --------------------------------------------------------
    logic rel_taken;
    logic tbit;
    logic bt_taken;
    logic [11:0] span;
    logic [11:0] ee_sx;
    logic [11:0] pc_nxt;

    always_comb
    begin
        unique case (kind)
            mcc_pkg::K_BR_NZ: rel_taken = !z_r; // RL4
            mcc_pkg::K_BR_Z: rel_taken = z_r; // RL4
            mcc_pkg::K_BR_NC: rel_taken = !c_r; // RL4
            mcc_pkg::K_BR_C: rel_taken = c_r; // RL4
            default: rel_taken = 1'b0;
        endcase
    end
    assign span = {8'h00, opc[mcc_pkg::SPAN_HI:0]};
    assign ee_sx = {{4{b1_r[7]}}, b1_r};
    assign tbit = c_r; // carry holds the tested bit from the read step on
    assign bt_taken = (opc[mcc_pkg::BOP_LO] == mcc_pkg::BOP_TEST_SET[0]) ? tbit : !tbit; // RL9

    always_comb
    begin
        pc_nxt = pc_r + mcc_pkg::PC_ONE;
        if (is_rel)
        begin
            // forward spans 1..16, backward spans 0..15 from the branch itself
            if (rel_taken)
                pc_nxt = opc[mcc_pkg::DIR_BIT] ? (pc_r - span)
                                               : (pc_r + mcc_pkg::PC_ONE + span); // RL5
        end
        else if (is_btest)
            pc_nxt = bt_taken ? (pc_r + mcc_pkg::PC_TWO + ee_sx)
                              : (pc_r + mcc_pkg::PC_THREE); // RL6
        else if (is_ext)
            pc_nxt = {opc[mcc_pkg::EXT_HI:0], b1_r}; // RL11
        else if (is_bit || (is_alu && (mode == mcc_pkg::MODE_DIRECT))
                 || (is_alu && two_opnd && (mode == mcc_pkg::MODE_IMM_ACC)))
            pc_nxt = pc_r + mcc_pkg::PC_TWO;
        else if ((kind == mcc_pkg::K_CTL) && ((ctl == mcc_pkg::CTL_RET)
                 || (ctl == mcc_pkg::CTL_IRET)))
            pc_nxt = stack_r[sp_r - 3'h1];
    end

    // --------------------------------------------------------
    // sequencer: step counter, run state, fetch address, stack
    // --------------------------------------------------------
    // waiting and stopped cores hold pc on the next instruction until wake
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            run_r <= mcc_pkg::RUN_ST;
            cnt_r <= mcc_pkg::STEP_OPC;
            op_r <= mcc_pkg::BYTE_ZERO;
            b1_r <= mcc_pkg::BYTE_ZERO;
            pc_r <= mcc_pkg::PC_RESET;
            pm_addr_r <= mcc_pkg::PC_RESET;
            sp_r <= 3'h0;
            for (int i = 0; i < mcc_pkg::STACK_DEPTH; i++)
                stack_r[i] <= mcc_pkg::PC_RESET;
        end
        else if (clk_en)
        begin
            unique case (run_r)
                mcc_pkg::RUN_ST:
                begin
                    if (cnt_r == mcc_pkg::STEP_OPC)
                    begin
                        op_r <= pm_rdata;
                        pm_addr_r <= pc_r + mcc_pkg::PC_ONE;
                    end
                    if (cnt_r == mcc_pkg::STEP_OPD)
                    begin
                        b1_r <= pm_rdata;
                        if (is_btest)
                            pm_addr_r <= pc_r + mcc_pkg::PC_TWO;
                    end
                    if (is_btest && (cnt_r == mcc_pkg::STEP_WRITE))
                        b1_r <= pm_rdata; // displacement byte
                    if (last_step)
                    begin
                        cnt_r <= mcc_pkg::STEP_OPC;
                        pc_r <= pc_nxt;
                        pm_addr_r <= pc_nxt;
                        if (is_ext && opc[mcc_pkg::EXT_CALL_BIT])
                        begin
                            stack_r[sp_r] <= pc_r + mcc_pkg::PC_TWO; // RL11
                            sp_r <= (sp_r == 3'h5) ? 3'h0 : sp_r + 3'h1;
                        end
                        if ((kind == mcc_pkg::K_CTL) && ((ctl == mcc_pkg::CTL_RET)
                            || (ctl == mcc_pkg::CTL_IRET)))
                            sp_r <= sp_r - 3'h1;
                        if ((kind == mcc_pkg::K_CTL) && (ctl == mcc_pkg::CTL_WAIT))
                            run_r <= mcc_pkg::WAIT_ST;
                        if ((kind == mcc_pkg::K_CTL) && (ctl == mcc_pkg::CTL_STOP))
                            run_r <= wdog_r ? mcc_pkg::WAIT_ST : mcc_pkg::STOP_ST; // RL10
                    end
                    else
                        cnt_r <= cnt_r + mcc_pkg::CNT_ONE;
                end
                default:
                begin
                    if (wake_r)
                        run_r <= mcc_pkg::RUN_ST;
                end
            endcase
        end
    end

    // --------------------------------------------------------
    // data space port
    // --------------------------------------------------------
    // the write strobe is a single pulse in the last step of a 4-cycle op
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dm_addr_r <= mcc_pkg::BYTE_ZERO;
            dm_wdata_r <= mcc_pkg::BYTE_ZERO;
            dm_we_r <= 1'b0;
        end
        else if (clk_en)
        begin
            dm_we_r <= 1'b0;
            if (run_r == mcc_pkg::RUN_ST)
            begin
                if ((cnt_r == mcc_pkg::STEP_OPC) && is_alu && (mode == mcc_pkg::MODE_IND_X))
                    dm_addr_r <= mcc_pkg::ADDR_PTR_X;
                if ((cnt_r == mcc_pkg::STEP_OPC) && is_alu && (mode == mcc_pkg::MODE_IND_Y))
                    dm_addr_r <= mcc_pkg::ADDR_PTR_Y;
                if (cnt_r == mcc_pkg::STEP_OPD)
                begin
                    // pointer contents for indirect, operand byte for direct and bit ops
                    if (is_alu && (mode <= mcc_pkg::MODE_IND_Y))
                        dm_addr_r <= dm_rdata;
                    else if (is_bit || (is_alu && (mode == mcc_pkg::MODE_DIRECT)))
                        dm_addr_r <= pm_rdata; // RL2 RL7
                end
                if (cnt_r == mcc_pkg::STEP_EXEC)
                begin
                    if (mem_target)
                    begin
                        dm_wdata_r <= alu_res; // RL2
                        dm_we_r <= 1'b1;
                    end
                    if (is_bit && opc[mcc_pkg::BOP_HI])
                    begin
                        dm_wdata_r <= dm_rdata;
                        dm_wdata_r[bitsel] <= (opc[mcc_pkg::BOP_HI:mcc_pkg::BOP_LO]
                                               == mcc_pkg::BOP_SET); // RL7
                        dm_we_r <= 1'b1;
                    end
                end
            end
        end
    end

    // --------------------------------------------------------
    // accumulator and flags
    // --------------------------------------------------------
    // clear to memory leaves flags alone; inc/dec keep carry
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            acc_r <= mcc_pkg::BYTE_ZERO;
            z_r <= 1'b0;
            c_r <= 1'b0;
        end
        else if (clk_en && (run_r == mcc_pkg::RUN_ST) && (cnt_r == mcc_pkg::STEP_EXEC))
        begin
            if ((is_alu && !mem_target && (alu_op != mcc_pkg::ALU_CMP)
                 && (alu_op != mcc_pkg::ALU_NONE)) || is_ctl_alu)
                acc_r <= alu_res; // RL1 RL3
            if ((is_alu && (alu_op != mcc_pkg::ALU_NONE)
                 && !(mem_target && (alu_op == mcc_pkg::ALU_CLR))) || is_ctl_alu)
                z_r <= alu_z; // RL12
            if ((is_alu && two_opnd) || is_ctl_alu
                || (is_alu && (alu_op == mcc_pkg::ALU_CLR) && !mem_target))
                c_r <= alu_c; // RL12
            if (is_btest)
                c_r <= dm_rdata[bitsel]; // RL8
        end
    end

    // --------------------------------------------------------
    // outputs
    // --------------------------------------------------------
    assign pm_addr = pm_addr_r;
    assign dm_addr = dm_addr_r;
    assign dm_wdata = dm_wdata_r;
    assign dm_we = dm_we_r;
    assign acc_out = acc_r;
    assign zero_flag = z_r;
    assign carry_flag = c_r;
    assign core_waiting = (run_r == mcc_pkg::WAIT_ST);
    assign core_stopped = (run_r == mcc_pkg::STOP_ST);

endmodule // mcc_core

`default_nettype wire

// *** bench/mcc_core_assertions.sv ***
// assertion checker for the core, bound onto its top ports
// assumes clk_en stays high so that each edge is one core step
`timescale 1ns/10ps
`default_nettype none
module mcc_core_checker
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [11:0] pm_addr,
    input wire logic [7:0] dm_addr,
    input wire logic dm_we,
    input wire logic wake_pin,
    input wire logic wdog_opt_pin,
    input wire logic core_waiting,
    input wire logic core_stopped,
    input wire logic [7:0] acc_out,
    input wire logic zero_flag,
    input wire logic carry_flag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // pins pass a three-stage filter, so the sleep checks allow a few edges of lag
    AST_WE_PULSE: assert property (dm_we && clk_en |=> !dm_we)
        else $error("write strobe too long");
    AST_WE_QUIET: assert property (dm_we |=> $stable(acc_out) && $stable(zero_flag)
        && $stable(carry_flag)) else $error("state moved after a write");
    AST_WE_ADDR: assert property (dm_we |-> $stable(dm_addr))
        else $error("write address moved");
    AST_ONE_SLEEP: assert property (!(core_waiting && core_stopped))
        else $error("wait and stop together");
    AST_WDOG_NO_STOP: assert property (not (wdog_opt_pin [*8] ##1 $rose(core_stopped)))
        else $error("stop entered under watchdog option");
    AST_WAKE_EXIT: assert property (wake_pin [*3] ##0 (core_waiting || core_stopped)
        |-> ##[1:6] !(core_waiting || core_stopped)) else $error("wake ignored");
    AST_SLEEP_HOLD: assert property (!wake_pin [*6] ##0 core_waiting |=> core_waiting)
        else $error("wait left without wake");
    AST_SLEEP_PC: assert property ((core_waiting || core_stopped)
        && $past(core_waiting || core_stopped) |-> $stable(pm_addr)) else $error("pc moved");
endmodule // mcc_core_checker
bind mcc_core mcc_core_checker mcc_core_checker_inst (.clk, .resetn, .clk_en, .pm_addr,
    .dm_addr, .dm_we, .wake_pin, .wdog_opt_pin, .core_waiting, .core_stopped, .acc_out,
    .zero_flag, .carry_flag);
`default_nettype wire

// *** bench/mcc_mem_model.sv ***
// program and data memory on the far side of the core
// assumes the bench preloads both arrays while the core is in reset
`timescale 1ns/10ps
`default_nettype none
module mcc_mem_model
(
    input wire logic clk,
    input wire logic [11:0] pm_addr,
    output logic [7:0] pm_rdata,
    input wire logic [7:0] dm_addr,
    input wire logic [7:0] dm_wdata,
    input wire logic dm_we,
    output logic [7:0] dm_rdata
);
    logic [7:0] pm [0:4095];
    logic [7:0] dm [0:255];
    // reads answer in the same cycle, the core samples them before the edge
    assign pm_rdata = pm[pm_addr];
    assign dm_rdata = dm[dm_addr];
    // plain always so the bench may also preload the array
    always @(posedge clk)
    begin
        if (dm_we === 1'b1)
        begin
            dm[dm_addr] <= dm_wdata;
        end
    end
endmodule // mcc_mem_model
`default_nettype wire

// *** bench/mcc_core_bench.sv ***
// self-checking bench: core against a memory model, one program per scenario, two in the sleep scenario
// assumes the model arrays may be written directly while the core is in reset
`timescale 1ns/10ps
`default_nettype none
module mcc_core_bench;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic wdog_opt_pin = 1'b0;
    logic wake_pin = 1'b0;
    logic [11:0] pm_addr;
    logic [7:0] pm_rdata, dm_addr, dm_wdata, dm_rdata, acc_out;
    logic dm_we, core_waiting, core_stopped, zero_flag, carry_flag;
    int n_fail = 0;
    int n_checks = 0;
    int n0;
    int n;
    // 100 ns period
    always #50 clk = ~clk;
    mcc_core mcc_core_inst (.clk, .resetn, .clk_en(1'b1), .pm_addr, .pm_rdata, .dm_addr,
        .dm_wdata, .dm_we, .dm_rdata, .wdog_opt_pin, .wake_pin, .core_waiting, .core_stopped,
        .acc_out, .zero_flag, .carry_flag);
    mcc_mem_model mcc_mem_model_inst (.clk, .pm_addr, .pm_rdata, .dm_addr, .dm_wdata,
        .dm_we, .dm_rdata);
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic load(input int a, input logic [7:0] q[$]);
        foreach (q[i]) mcc_mem_model_inst.pm[a + i] = q[i];
    endtask
    // cycles are counted relative to a lone wait, so reset latency cancels out
    task automatic run(output int cnt);
        resetn = 1'b0;
        repeat (6) @(posedge clk);
        #1 resetn = 1'b1;
        cnt = 0;
        do
        begin
            @(posedge clk);
            #1 cnt++;
        end while ((core_waiting | core_stopped) !== 1'b1 && cnt < 300);
        if (cnt >= 300)
        begin
            n_fail++;
            complete_run();
        end
    endtask
    task automatic s_base();
        for (int i = 0; i < 4096; i++) mcc_mem_model_inst.pm[i] = 8'he4;
        run(n0);
        chk(pm_addr, 12'h001);
    endtask
    task automatic s_alu();
        load(0, '{8'hc3, 8'hf0, 8'he5, 8'he6, 8'he7, 8'hdb, 8'hca, 8'h10, 8'hda, 8'hff, 8'he4});
        mcc_mem_model_inst.dm[8'h10] = 8'h40;
        mcc_mem_model_inst.dm[8'hff] = 8'h41;
        run(n);
        chk(n[11:0], n0[11:0] + 12'h01c);
        chk({4'h0, acc_out}, 12'h03f);
        chk({zero_flag, carry_flag}, 12'h001);
        chk({4'h0, mcc_mem_model_inst.dm[8'h10]}, 12'h040);
        chk({4'h0, mcc_mem_model_inst.dm[8'hff]}, 12'h042);
    endtask
    task automatic s_branch();
        load(0, '{8'h23, 8'h4f, 8'h65, 8'hd5, 8'he4});
        load(17, '{8'h1f});
        mcc_mem_model_inst.dm[8'h81] = 8'h30;
        mcc_mem_model_inst.dm[8'h30] = 8'h05;
        run(n);
        chk(n[11:0], n0[11:0] + 12'h00c);
        chk(pm_addr, 12'h005);
        chk({4'h0, mcc_mem_model_inst.dm[8'h30]}, 12'h004);
    endtask
    task automatic s_bits();
        load(0, '{8'hd3, 8'h97, 8'h20, 8'h8f, 8'h20, 8'h7f});
        load(12'h084, '{8'h98, 8'h20, 8'h80, 8'h20, 8'h80});
        load(8, '{8'he4});
        mcc_mem_model_inst.dm[8'h20] = 8'h01;
        run(n);
        chk(n[11:0], n0[11:0] + 12'h016);
        chk(pm_addr, 12'h009);
        chk({zero_flag, carry_flag}, 12'h002);
        chk({4'h0, mcc_mem_model_inst.dm[8'h20]}, 12'h080);
    endtask
    task automatic s_sleep();
        load(0, '{8'he3});
        run(n);
        chk({core_stopped, core_waiting}, 12'h002);
        wdog_opt_pin = 1'b1;
        load(0, '{8'hb3, 8'h45, 8'he0, 8'he0, 8'he0, 8'he0, 8'he0, 8'he0, 8'he0, 8'he0, 8'he4});
        load(12'h345, '{8'haa, 8'hbc});
        load(12'habc, '{8'he3, 8'he1});
        run(n);
        chk(n[11:0], n0[11:0] + 12'h008);
        chk({core_stopped, core_waiting}, 12'h001);
        chk(pm_addr, 12'habd);
        wake_pin = 1'b1;
        repeat (3) @(posedge clk);
        #1 wake_pin = 1'b0;
        repeat (40) @(posedge clk);
        #1 chk(pm_addr, 12'h00b);
        chk({core_stopped, core_waiting}, 12'h001);
    endtask
    initial
    begin
        s_base();
        s_alu();
        s_branch();
        s_bits();
        s_sleep();
        complete_run();
    end
endmodule // mcc_core_bench
`default_nettype wire
